/* File: motion_status_map.svh */
// Register offsets, field positions, reset values and timing counts of the status block
`ifndef MOTION_STATUS_MAP_SVH
`define MOTION_STATUS_MAP_SVH

`define OFF_CTRL 8'h00
`define OFF_COMM 8'h04
`define OFF_TEMP 8'h08
`define OFF_VOLT 8'h0c
`define OFF_MOVE 8'h10
`define OFF_ZONE_FIRST 8'h14
`define OFF_ZONE_LAST 8'h28
`define OFF_STATUS 8'h2c

`define CTRL_HOMEFLT_BIT 0
`define CTRL_ORGMODE_BIT 1
`define CTRL_STEP_LSB 2
`define COMM_ERRLIM_LSB 16
`define VOLT_UNDER_LSB 16

`define STEP_NONE 2'h0
`define STEP_WARN 2'h1
`define STEP_FAULT 2'h2

`define RST_TIMEOUT 14'h0000
`define MAX_TIMEOUT 14'h2710
`define RST_ERRLIM 4'h3
`define MIN_ERRLIM 4'h1
`define MAX_ERRLIM 4'ha
`define RST_HEAT 7'h55
`define MIN_HEAT 7'h28
`define MAX_HEAT 7'h55
`define RST_OVER 9'h1b3
`define MIN_OVER 9'h078
`define MAX_OVER 9'h1c2
`define RST_UNDER 9'h078
`define MIN_UNDER 9'h078
`define MAX_UNDER 9'h118
`define RST_MINON 8'h00
`define RST_BOUND 24'h000000

`define CLK_PERIOD_NS 32'h0000000a
`define MS_NS 32'h000f4240
`define MS_CYCLES (`MS_NS / `CLK_PERIOD_NS)
`define BLINK_MS 32'h000000fa

`endif

/* File: motion_status_pkg.sv */
// Types shared by the status block and its helpers
package motion_status_pkg;

  typedef logic signed [23:0] zone_pos_t;

  typedef enum logic {FLT_NONE, FLT_HELD} fault_state_t;

  typedef struct packed {
    logic homeFaultEn;
    logic originMode;
    logic [1:0] stepoutAction;
    logic [13:0] timeoutMs;
    logic [3:0] errLimit;
    logic [6:0] heatC;
    logic [8:0] overVolt;
    logic [8:0] underVolt;
    logic [7:0] minOnMs;
    logic [5:0][23:0] bounds;
  } cfg_t;

endpackage : motion_status_pkg

/* File: status_link_if.sv */
// Signals between the status top and its motion and zone helpers
`timescale 1ns/10ps
interface status_link_if
  import motion_status_pkg::*;
;
  logic ce;
  logic msTick;
  logic motorBusy;
  logic [7:0] minOnMs;
  logic moveOut;
  zone_pos_t cmdPos;
  zone_pos_t posBound [3];
  zone_pos_t negBound [3];
  logic [2:0] zoneHit;

  modport top (output ce, msTick, motorBusy, minOnMs, cmdPos, posBound, negBound,
               input moveOut, zoneHit);
  modport stretch (input ce, msTick, motorBusy, minOnMs, output moveOut);
  modport zone (input ce, cmdPos, posBound, negBound, output zoneHit);
endinterface : status_link_if

/* File: move_stretch.sv */
// Motion-active output with a minimum on time in milliseconds
`timescale 1ns/10ps
module move_stretch
  import motion_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  status_link_if.stretch lnk
);

  logic [8:0] holdMs, next_holdMs;
  logic moving, next_moving;

  always_comb begin
    next_holdMs = holdMs;
    next_moving = moving;
    if (lnk.ce) begin
      if (lnk.motorBusy) begin
        next_moving = 1'b1;
        if (!moving) begin
          // One extra tick so a partial first millisecond never shortens the hold
          next_holdMs = (lnk.minOnMs == 8'h00) ? 9'h000 : {1'b0, lnk.minOnMs} + 9'h001;
        end else if (lnk.msTick && holdMs != 9'h000) begin
          next_holdMs = holdMs - 9'h001;
        end
      end else if (holdMs != 9'h000) begin
        next_moving = 1'b1;
        if (lnk.msTick) begin
          next_holdMs = holdMs - 9'h001;
        end
      end else begin
        next_moving = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      holdMs <= 9'h000;
      moving <= 1'b0;
    end else begin
      holdMs <= next_holdMs;
      moving <= next_moving;
    end
  end

  assign lnk.moveOut = moving;

  a_move_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lnk.ce && moving && holdMs != 9'h000) |=> moving)
    else $error("motion output dropped inside minimum on time");

  a_move_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lnk.ce && lnk.motorBusy) |=> moving)
    else $error("motion output off while motor busy");

endmodule : move_stretch

/* File: zone_compare.sv */
// Three position-zone comparators on the command position
`timescale 1ns/10ps
module zone_compare
  import motion_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  status_link_if.zone lnk
);

  function automatic logic inZone(input zone_pos_t pb, input zone_pos_t nb, input zone_pos_t x);
    if (pb > nb) begin
      inZone = (x >= nb) && (x <= pb);
    end else if (pb < nb) begin
      inZone = (x <= pb) || (x >= nb);
    end else begin
      inZone = (x == pb);
    end
  endfunction : inZone

  logic [2:0] hit, next_hit;

  for (genvar g = 0; g < 3; g++) begin : g_zone
    always_comb begin
      next_hit[g] = hit[g];
      if (lnk.ce) begin
        next_hit[g] = inZone(lnk.posBound[g], lnk.negBound[g], lnk.cmdPos);
      end
    end

    a_zone_point: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (lnk.ce && lnk.posBound[g] == lnk.negBound[g])
        |=> hit[g] == ($past(lnk.cmdPos) == $past(lnk.posBound[g])))
      else $error("point zone output wrong");
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hit <= 3'h0;
    end else begin
      hit <= next_hit;
    end
  end

  assign lnk.zoneHit = hit;

endmodule : zone_compare

/* File: motion_status_outputs.sv */
// Status outputs of a stepping motor driver: fault, caution, ready, origin, motion, zones
//
// Operation
// - Closed-type lines conduct when deasserted
// - Discrete fault line opens on fault
// - Network fault bit is one on fault
// - Fault blinks lamp, cuts current, stops motor
// - Positioning without origin may raise fault
// - Link silence beyond timeout raises fault
// - Deviation band acts per two-bit setting
// - Caution asserts on any warning
// - Temperature at threshold warns
// - Over and under voltage warn
// - Ready needs idle inputs, no fault
// - Ready low while tools or link busy
// - Origin mode selects home or complete
// - Home mode: at zero, stopped, origin set
// - Complete mode: holds until moved away
// - Motion output follows motor, minimum time
// - Zone outputs assert inside zone
// - Equal bounds mean exact position match
// - Zones compare command position
// - Rising clear input clears fault
`timescale 1ns/10ps
`include "motion_status_map.svh"
module motion_status_outputs
  import motion_status_pkg::*;
#(
  parameter int CYC_PER_MS = `MS_CYCLES,
  parameter int BLINK_MS = `BLINK_MS
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic startInputs,
  input wire logic shaftRelease,
  input wire logic deenergize_input,
  input wire logic stopInput,
  input wire logic motorBusy,
  input wire logic toolBusy,
  input wire logic linkCfgBusy,
  input wire logic positionStart,
  input wire logic originSet,
  input wire logic [23:0] cmdPos,
  input wire logic linkFrame,
  input wire logic linkError,
  input wire logic deviationReached,
  input wire logic [7:0] tempC,
  input wire logic [8:0] internalVolt,
  input wire logic fault_clear_input,
  output logic fault_out,
  output logic faultNet,
  output logic fault_lamp,
  output logic currentCut,
  output logic motorStop,
  output logic caution_out,
  output logic readyOut,
  output logic originOut,
  output logic moveOut,
  output logic zone_one_out,
  output logic zone_two_out,
  output logic zone_three_out
);

  if (CYC_PER_MS < 1 || CYC_PER_MS > 16777215) begin : g_bad_ms
    $error("CYC_PER_MS must fit a 24-bit prescaler");
  end
  if (BLINK_MS < 1 || BLINK_MS > 255) begin : g_bad_blink
    $error("BLINK_MS must be 1 to 255");
  end

  localparam logic [23:0] MS_LAST = 24'(CYC_PER_MS - 1);
  localparam logic [7:0] BLINK_LAST = 8'(BLINK_MS - 1);

  status_link_if lnk ();

  // Millisecond tick
  logic [23:0] prescale, next_prescale;
  logic msTick, next_msTick;

  always_comb begin
    next_prescale = prescale;
    next_msTick = 1'b0;
    if (ce) begin
      if (prescale == MS_LAST) begin
        next_prescale = 24'h000000;
        next_msTick = 1'b1;
      end else begin
        next_prescale = prescale + 24'h000001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prescale <= 24'h000000;
      msTick <= 1'b0;
    end else begin
      prescale <= next_prescale;
      msTick <= next_msTick;
    end
  end

  // APB slave and settings
  cfg_t cfg, next_cfg;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [3:0] cause, next_cause;
  logic [3:0] warnNow;
  logic [3:0] errCnt, next_errCnt;
  logic originValid, next_originValid;
  fault_state_t fstate, next_fstate;

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a <= `OFF_STATUS);
  endfunction : isMapped

  function automatic logic [31:0] regRead(input logic [7:0] a);
    logic [4:0] idx;
    idx = 5'((a - `OFF_ZONE_FIRST) >> 2);
    regRead = 32'h00000000;
    case (a)
      `OFF_CTRL: regRead = {28'h0000000, cfg.stepoutAction, cfg.originMode, cfg.homeFaultEn};
      `OFF_COMM: regRead = {12'h000, cfg.errLimit, 2'h0, cfg.timeoutMs};
      `OFF_TEMP: regRead = {25'h0000000, cfg.heatC};
      `OFF_VOLT: regRead = {7'h00, cfg.underVolt, 7'h00, cfg.overVolt};
      `OFF_MOVE: regRead = {24'h000000, cfg.minOnMs};
      `OFF_STATUS: regRead = {11'h000, originValid, errCnt, warnNow, cause, zone_three_out,
                              zone_two_out, zone_one_out, moveOut, originOut, readyOut,
                              caution_out, faultNet};
      default: begin
        if (a >= `OFF_ZONE_FIRST && a <= `OFF_ZONE_LAST) begin
          regRead = {{8{cfg.bounds[idx[2:0]][23]}}, cfg.bounds[idx[2:0]]};
        end
      end
    endcase
  endfunction : regRead

  always_comb begin
    logic [4:0] widx;
    widx = 5'((paddr - `OFF_ZONE_FIRST) >> 2);
    next_cfg = cfg;
    next_pready = pready;
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (ce) begin
      // Answer one cycle into the access phase
      next_pready = psel && penable && !pready;
      if (psel && penable && !pready) begin
        next_prdata = (!pwrite && isMapped(paddr)) ? regRead(paddr) : 32'h00000000;
        next_pslverr = !isMapped(paddr);
      end
      // Out-of-range values are refused and the old setting kept
      if (psel && penable && pready && pwrite && isMapped(paddr)) begin
        case (paddr)
          `OFF_CTRL: begin
            next_cfg.homeFaultEn = pwdata[`CTRL_HOMEFLT_BIT];
            next_cfg.originMode = pwdata[`CTRL_ORGMODE_BIT];
            if (pwdata[`CTRL_STEP_LSB+:2] <= `STEP_FAULT) begin
              next_cfg.stepoutAction = pwdata[`CTRL_STEP_LSB+:2];
            end
          end
          `OFF_COMM: begin
            if (pwdata[15:0] <= {2'h0, `MAX_TIMEOUT}) begin
              next_cfg.timeoutMs = pwdata[13:0];
            end
            if (pwdata[`COMM_ERRLIM_LSB+:4] >= `MIN_ERRLIM &&
                pwdata[`COMM_ERRLIM_LSB+:4] <= `MAX_ERRLIM) begin
              next_cfg.errLimit = pwdata[`COMM_ERRLIM_LSB+:4];
            end
          end
          `OFF_TEMP: begin
            if (pwdata[7:0] >= {1'b0, `MIN_HEAT} && pwdata[7:0] <= {1'b0, `MAX_HEAT}) begin
              next_cfg.heatC = pwdata[6:0];
            end
          end
          `OFF_VOLT: begin
            if (pwdata[8:0] >= `MIN_OVER && pwdata[8:0] <= `MAX_OVER) begin
              next_cfg.overVolt = pwdata[8:0];
            end
            if (pwdata[`VOLT_UNDER_LSB+:9] >= `MIN_UNDER &&
                pwdata[`VOLT_UNDER_LSB+:9] <= `MAX_UNDER) begin
              next_cfg.underVolt = pwdata[`VOLT_UNDER_LSB+:9];
            end
          end
          `OFF_MOVE: next_cfg.minOnMs = pwdata[7:0];
          `OFF_STATUS: next_cfg = cfg;
          default: begin
            if (paddr >= `OFF_ZONE_FIRST && paddr <= `OFF_ZONE_LAST) begin
              next_cfg.bounds[widx[2:0]] = pwdata[23:0];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= '{homeFaultEn: 1'b0, originMode: 1'b0, stepoutAction: `STEP_NONE,
               timeoutMs: `RST_TIMEOUT, errLimit: `RST_ERRLIM, heatC: `RST_HEAT,
               overVolt: `RST_OVER, underVolt: `RST_UNDER, minOnMs: `RST_MINON,
               bounds: {6{`RST_BOUND}}};
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Link watch, fault latch and origin bookkeeping
  logic [13:0] idleMs, next_idleMs;
  logic clrPrev, next_clrPrev;
  logic clearRise;
  logic [3:0] causeNow;

  assign clearRise = fault_clear_input && !clrPrev;

  always_comb begin
    causeNow[0] = cfg.homeFaultEn && positionStart && !originValid;
    // error count limit
    // Clear rise restarts both counts, so one rise can clear these causes
    causeNow[1] = (errCnt >= cfg.errLimit) && !clearRise;
    causeNow[2] = (cfg.timeoutMs != 14'h0000) && (idleMs > cfg.timeoutMs) && !clearRise;
    causeNow[3] = deviationReached && (cfg.stepoutAction == `STEP_FAULT);
    warnNow[0] = (tempC >= {1'b0, cfg.heatC});
    warnNow[1] = (internalVolt >= cfg.overVolt);
    warnNow[2] = (internalVolt <= cfg.underVolt);
    warnNow[3] = deviationReached && (cfg.stepoutAction == `STEP_WARN);
  end

  always_comb begin
    next_idleMs = idleMs;
    next_errCnt = errCnt;
    next_clrPrev = clrPrev;
    next_cause = cause;
    next_fstate = fstate;
    next_originValid = originValid;
    if (ce) begin
      next_clrPrev = fault_clear_input;
      if (linkFrame || clearRise) begin
        next_idleMs = 14'h0000;
      end else if (msTick && idleMs != 14'h3fff) begin
        next_idleMs = idleMs + 14'h0001;
      end
      if (clearRise) begin
        next_errCnt = 4'h0;
      end
      if (linkError && errCnt != 4'hf) begin
        next_errCnt = (clearRise ? 4'h0 : errCnt) + 4'h1;
      end
      next_cause = (clearRise ? 4'h0 : cause) | causeNow;
      case (fstate)
        FLT_NONE: begin
          if (causeNow != 4'h0) begin
            next_fstate = FLT_HELD;
          end
        end
        FLT_HELD: begin
          if (clearRise && causeNow == 4'h0) begin
            next_fstate = FLT_NONE;
          end
        end
        default: next_fstate = FLT_NONE;
      endcase
      if (originSet) begin
        next_originValid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      idleMs <= 14'h0000;
      errCnt <= 4'h0;
      clrPrev <= 1'b0;
      cause <= 4'h0;
      fstate <= FLT_NONE;
      originValid <= 1'b0;
    end else begin
      idleMs <= next_idleMs;
      errCnt <= next_errCnt;
      clrPrev <= next_clrPrev;
      cause <= next_cause;
      fstate <= next_fstate;
      originValid <= next_originValid;
    end
  end

  // Registered outputs
  logic [7:0] blinkMs, next_blinkMs;
  logic homeDone, next_homeDone;
  logic next_faultNet, next_fault_out, next_fault_lamp, next_caution_out;
  logic next_readyOut, next_originOut;
  logic faultNow;

  assign faultNow = (next_fstate == FLT_HELD);

  always_comb begin
    next_blinkMs = blinkMs;
    next_homeDone = homeDone;
    next_faultNet = faultNet;
    next_fault_out = fault_out;
    next_fault_lamp = fault_lamp;
    next_caution_out = caution_out;
    next_readyOut = readyOut;
    next_originOut = originOut;
    if (ce) begin
      next_faultNet = faultNow;
      next_fault_out = !faultNow;
      if (!faultNow) begin
        next_blinkMs = 8'h00;
        next_fault_lamp = 1'b0;
      end else if (fstate == FLT_NONE) begin
        next_fault_lamp = 1'b1;
      end else if (msTick) begin
        if (blinkMs == BLINK_LAST) begin
          next_blinkMs = 8'h00;
          next_fault_lamp = !fault_lamp;
        end else begin
          next_blinkMs = blinkMs + 8'h01;
        end
      end
      next_caution_out = (warnNow != 4'h0);
      next_readyOut = !startInputs && !shaftRelease && !deenergize_input && !stopInput &&
                      !faultNow && !motorBusy && !toolBusy && !linkCfgBusy;
      if (originSet) begin
        next_homeDone = 1'b1;
      end else if (cmdPos != 24'h000000) begin
        next_homeDone = 1'b0;
      end
      next_originOut = cfg.originMode ? next_homeDone :
                       (next_originValid && cmdPos == 24'h000000 && !moveOut);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      blinkMs <= 8'h00;
      homeDone <= 1'b0;
      faultNet <= 1'b0;
      fault_out <= 1'b1;
      fault_lamp <= 1'b0;
      currentCut <= 1'b0;
      motorStop <= 1'b0;
      caution_out <= 1'b0;
      readyOut <= 1'b0;
      originOut <= 1'b0;
    end else begin
      blinkMs <= next_blinkMs;
      homeDone <= next_homeDone;
      faultNet <= next_faultNet;
      fault_out <= next_fault_out;
      fault_lamp <= next_fault_lamp;
      currentCut <= next_faultNet;
      motorStop <= next_faultNet;
      caution_out <= next_caution_out;
      readyOut <= next_readyOut;
      originOut <= next_originOut;
    end
  end

  // Helpers
  assign lnk.ce = ce;
  assign lnk.msTick = msTick;
  assign lnk.motorBusy = motorBusy;
  assign lnk.minOnMs = cfg.minOnMs;
  assign lnk.cmdPos = zone_pos_t'(cmdPos);
  for (genvar g = 0; g < 3; g++) begin : g_bound
    assign lnk.posBound[g] = zone_pos_t'(cfg.bounds[2*g]);
    assign lnk.negBound[g] = zone_pos_t'(cfg.bounds[2*g+1]);
  end

  move_stretch u_move (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk.stretch));
  zone_compare u_zone (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk.zone));

  assign moveOut = lnk.moveOut;
  assign zone_one_out = lnk.zoneHit[0];
  assign zone_two_out = lnk.zoneHit[1];
  assign zone_three_out = lnk.zoneHit[2];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_fault_lines: assert property ((ce && causeNow != 4'h0) |=> faultNet && !fault_out)
    else $error("fault lines not raised");
  a_fault_stop: assert property (faultNet |-> currentCut && motorStop)
    else $error("fault without current cut");
  a_fault_latch: assert property ((ce && faultNet && !clearRise) |=> faultNet)
    else $error("fault dropped without clear");
  a_fault_clear: assert property (
    (ce && fstate == FLT_HELD && clearRise && causeNow == 4'h0) |=> !faultNet ##0 fault_out)
    else $error("fault not cleared by rising clear");
  a_homing_fault: assert property (
    (ce && positionStart && !originValid && cfg.homeFaultEn) |=> cause[0] && faultNet)
    else $error("homing fault missing");
  a_link_timeout: assert property (
    (ce && !clearRise && cfg.timeoutMs != 14'h0000 && idleMs > cfg.timeoutMs) |=> cause[2])
    else $error("link timeout not raised");
  a_err_limit: assert property ((ce && !clearRise && errCnt >= cfg.errLimit) |=> cause[1])
    else $error("error limit fault missing");
  a_ready_block: assert property ((ce && (motorBusy || stopInput || faultNow)) |=> !readyOut)
    else $error("ready while blocked");
  a_ready_tool: assert property ((ce && (toolBusy || linkCfgBusy)) |=> !readyOut)
    else $error("ready while tool busy");
  a_caution_heat: assert property ((ce && tempC >= {1'b0, cfg.heatC}) |=> caution_out)
    else $error("overheat caution missing");
  a_origin_unset: assert property ((ce && !cfg.originMode && !next_originValid) |=> !originOut)
    else $error("origin shown without origin");
  a_apb_answer: assert property ((ce && psel && penable && !pready) |=> pready ##1 !pready)
    else $error("bus answer timing wrong");

endmodule : motion_status_outputs

/* File: host_model.sv */
// Host model that starts a positioning move only once the driver is ready
`timescale 1ns/10ps
module host_model (
  input wire logic clk_sys,
  input wire logic readyOut,
  input wire logic go,
  output logic positionStart
);
  initial positionStart = 1'b0;
  always @(posedge clk_sys) begin
    positionStart <= go && readyOut && !positionStart;
  end
endmodule : host_model

/* File: testbench.sv */
// Self-checking bench for the status outputs
`timescale 1ns/10ps
module testbench;
  import motion_status_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, r;
  logic [31:0] seed = 32'hc19c8757;
  logic pready, pslverr, err, positionStart;
  logic go = 1'b0;
  logic [6:0] idle = 7'h00;
  logic originSet = 1'b0;
  logic linkFrame = 1'b0;
  logic linkError = 1'b0;
  logic dev = 1'b0;
  logic clr = 1'b0;
  logic [23:0] cmdPos = 24'h0;
  logic [7:0] tempC = 8'h00;
  logic [8:0] volt = 9'h0c8;
  logic fault_out, faultNet, fault_lamp, currentCut, motorStop, caution_out;
  logic readyOut, originOut, moveOut, z1, z2, z3;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int pb[3] = '{10, -10, 5};
  int nb[3] = '{-10, 10, 5};

  motion_status_outputs #(.CYC_PER_MS(10), .BLINK_MS(2)) dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .startInputs(idle[0]),
    .shaftRelease(idle[1]), .deenergize_input(idle[3]), .stopInput(idle[4]),
    .motorBusy(idle[2]), .toolBusy(idle[5]), .linkCfgBusy(idle[6]),
    .positionStart(positionStart), .originSet(originSet), .cmdPos(cmdPos),
    .linkFrame(linkFrame), .linkError(linkError), .deviationReached(dev),
    .tempC(tempC), .internalVolt(volt), .fault_clear_input(clr),
    .fault_out(fault_out), .faultNet(faultNet), .fault_lamp(fault_lamp),
    .currentCut(currentCut), .motorStop(motorStop), .caution_out(caution_out),
    .readyOut(readyOut), .originOut(originOut), .moveOut(moveOut),
    .zone_one_out(z1), .zone_two_out(z2), .zone_three_out(z3)
  );
  host_model host (.clk_sys(clk_sys), .readyOut(readyOut), .go(go),
    .positionStart(positionStart));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic zm(int p, int n, int x);
    if (p == n) return x == p;
    if (p > n) return x <= p && x >= n;
    return x <= p || x >= n;
  endfunction : zm

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic tick(int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick

  // Rising edge on the clear input, then back low
  task automatic rise();
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    tick(1);
  endtask : rise

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 5000) begin
      chk(32'h0, 32'h1);
      conclude();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h00030000);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h00000055);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 32'h007801b3);
    apb(1'b1, 8'h30, 32'h1);
    chk(err, 1'b1);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 8'(8'h14 + 8 * i), pb[i]);
      apb(1'b1, 8'(8'h18 + 8 * i), nb[i]);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'hfffffff6);
    repeat (200) begin
      @(posedge clk_sys);
      r = rnd();
      idle <= (r[2:0] == 3'h0) ? r[9:3] : 7'h00;
      tempC <= 8'h50 + r[14:12];
      cmdPos <= 24'($signed(r[20:16]));
      tick(1);
      chk(readyOut, idle == 7'h00);
      chk(moveOut, idle[2]);
      chk(caution_out, tempC >= 8'h55);
      chk(z1, zm(pb[0], nb[0], $signed(cmdPos)));
      chk(z2, zm(pb[1], nb[1], $signed(cmdPos)));
      chk(z3, zm(pb[2], nb[2], $signed(cmdPos)));
    end
    @(posedge clk_sys);
    idle <= 7'h00;
    cmdPos <= 24'h0;
    tempC <= 8'h00;
    apb(1'b1, 8'h00, 32'h1);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    tick(2);
    chk({faultNet, fault_out, currentCut, motorStop, fault_lamp, readyOut}, 6'h2e);
    tick(50);
    chk({faultNet, currentCut, fault_out}, 3'h6);
    @(posedge clk_sys);
    clr <= 1'b1;
    tick(1);
    chk({faultNet, fault_out}, 2'h1);
    @(posedge clk_sys);
    clr <= 1'b0;
    originSet <= 1'b1;
    @(posedge clk_sys);
    originSet <= 1'b0;
    tick(2);
    chk(originOut, 1'b1);
    @(posedge clk_sys);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    tick(3);
    chk(faultNet, 1'b0);
    apb(1'b1, 8'h00, 32'h3);
    tick(2);
    chk(originOut, 1'b1);
    @(posedge clk_sys);
    cmdPos <= 24'h5;
    tick(2);
    chk({originOut, z3}, 2'h1);
    @(posedge clk_sys);
    ce <= 1'b0;
    cmdPos <= 24'h0;
    tick(3);
    chk(z3, 1'b1);
    @(posedge clk_sys);
    ce <= 1'b1;
    tick(2);
    chk({originOut, z3}, 2'h0);
    @(posedge clk_sys);
    dev <= 1'b1;
    apb(1'b1, 8'h00, 32'h4);
    tick(1);
    chk({caution_out, faultNet}, 2'h2);
    apb(1'b1, 8'h00, 32'hc);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00000004);
    apb(1'b1, 8'h00, 32'h8);
    tick(1);
    chk({caution_out, faultNet}, 2'h1);
    rise();
    chk(faultNet, 1'b1);
    @(posedge clk_sys);
    dev <= 1'b0;
    rise();
    chk({faultNet, fault_lamp}, 2'h0);
    repeat (5) begin
      @(posedge clk_sys);
      linkError <= !linkError;
    end
    tick(1);
    chk(faultNet, 1'b0);
    @(posedge clk_sys);
    linkError <= 1'b0;
    tick(1);
    chk(faultNet, 1'b1);
    rise();
    chk(faultNet, 1'b0);
    apb(1'b1, 8'h04, 32'h00030005);
    tick(20);
    chk(faultNet, 1'b0);
    tick(60);
    chk(faultNet, 1'b1);
    apb(1'b1, 8'h04, 32'h00030000);
    rise();
    chk(faultNet, 1'b0);
    @(posedge clk_sys);
    volt <= 9'h1c0;
    tick(2);
    chk(caution_out, 1'b1);
    @(posedge clk_sys);
    volt <= 9'h064;
    tick(2);
    chk(caution_out, 1'b1);
    @(posedge clk_sys);
    volt <= 9'h0c8;
    tick(2);
    chk(caution_out, 1'b0);
    conclude();
  end
endmodule : testbench
